// File: bench/rcc_cfg_regs_bench.sv
// self-checking bench of the read-channel configuration register bank
module rcc_cfg_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import rcc_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        sg = 1'b0, wots = 1'b0, pp = 1'b0, pn = 1'b0, sp = 1'b0, fp = 1'b0;
   logic        cyc, stb, we, ack, ens, ecl, po, oen, aen, sh, fa, r20, cs;
   logic [2:0]  hold;
   logic [3:0]  lo, hi, sel;
   logic [4:0]  hws;
   logic [7:0]  adr;
   logic [31:0] wdat, rdat;
   int          n_mismatch = 0;
   int          tests_run = 0;
   int          cycles = 0;

   always #10 clk_i = ~clk_i;

   rcc_cfg_regs #(.COUNT_DIV(1)) rcc_cfg_regs_i (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .servo_gate_i(sg), .write_out_type_select_i(wots), .pulse_pos_i(pp),
      .pulse_neg_i(pn), .short_pin_i(sp), .fast_attack_pin_i(fp),
      .hold_rate_sel_o(hold), .env_slice_active_o(ens), .low_slice_o(lo),
      .high_slice_o(hi), .half_window_step_o(hws), .ecl_load_on_o(ecl),
      .detected_pulse_output_o(po), .detected_pulse_output_oe_n_o(oen),
      .agc_diff_outputs_en_o(aen), .agc_input_short_o(sh), .fast_attack_o(fa),
      .agc_ratio_20_o(r20), .agc_charge_small_o(cs));

   rcc_host_model rcc_host_model_i (
      .clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
      .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ceiling well above the fewer than one thousand cycles the scenarios need
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         n_mismatch++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      rcc_host_model_i.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      rcc_host_model_i.xfer(1'b0, a, 32'h0, q);
   endtask
   // outputs are registered one edge behind the config, so allow two
   task automatic settle();
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   task automatic count_hi(input bit f, input int n, inout int c);
      repeat (n) begin
         @(negedge clk_i);
         c += f ? int'(fa) : int'(sh);
      end
   endtask

   task automatic t_reset();
      logic [31:0] q;
      logic [4:0] idx [8] = '{IDX_SRV_MODE, IDX_HALF_WIN, IDX_AGC_SHORT, IDX_FAST_ATT,
                              IDX_FA_WIDTH, IDX_RD_SLICE, IDX_SV_SLICE, 5'h16};
      settle();
      chk(hold, 3'b100);
      chk(oen, 1'b1);
      foreach (idx[i]) begin
         rd({1'b0, idx[i], 2'b00}, q);
         chk(q, 32'h0);
      end
   endtask
   task automatic t_mode();
      logic [31:0] q;
      for (int c = 0; c < 3; c++) begin
         wr(8'h34, {24'h0, 1'b1, 5'h1F, c[1:0]});
         for (int g = 0; g < 2; g++) begin
            @(posedge clk_i);
            sg <= g[0];
            settle();
            chk(hold, 3'b100 >> c);
            chk(ens, !g[0]);
         end
      end
      rd(8'h34, q);
      chk(q, 32'h82);
      wr(8'h34, 32'h0);
      settle();
      chk(ens, 1'b0);
   endtask
   task automatic t_slice();
      wr(8'h50, 32'h5A);
      wr(8'h54, 32'hF0);
      for (int g = 0; g < 2; g++) begin
         @(posedge clk_i);
         sg <= g[0];
         settle();
         chk(lo, g ? 4'h0 : 4'hA);
         chk(hi, g ? 4'hF : 4'h5);
      end
   endtask
   task automatic t_half();
      for (int s = 3; s < 8; s++) begin
         wr(8'h3C, {24'h0, s[4:0], 3'b100});
         @(posedge clk_i);
         wots <= s[0];
         settle();
         chk(hws, s[4:0]);
         chk(ecl, s[0]);
      end
   endtask
   task automatic t_pulse();
      wr(8'h44, 32'h80);
      settle();
      chk(oen, 1'b0);
      for (int k = 0; k < 4; k++) begin
         wr(8'h3C, {24'h0, 5'd3, 1'b0, k[1:0]});
         @(posedge clk_i);
         pp <= 1'b1;
         pn <= 1'b0;
         settle();
         chk(po, !k[0]);
         @(posedge clk_i);
         pp <= 1'b0;
         pn <= 1'b1;
         settle();
         chk(po, k[0] ^ k[1]);
      end
      @(posedge clk_i);
      pn <= 1'b0;
      wr(8'h44, 32'h0);
      settle();
      chk(oen, 1'b1);
   endtask
   task automatic t_short();
      int c;
      logic [5:0] code [3] = '{6'd0, 6'd1, 6'd63};
      int exp [3] = '{0, 3, 65};
      for (int i = 0; i < 3; i++) begin
         c = 0;
         // count alongside the write: the timer starts at the taking edge, where ack also rises, one edge before the host sees ack
         fork
            wr(8'h44, {24'h0, 1'b0, i == 1, code[i]});
            count_hi(1'b0, 80, c);
         join
         chk(c, exp[i]);
         chk(aen, i == 1);
      end
      @(posedge clk_i);
      sp <= 1'b1;
      settle();
      chk(sh, 1'b1);
      @(posedge clk_i);
      sp <= 1'b0;
   endtask
   task automatic t_fast();
      int c;
      int exp [5] = '{0, 5, 7, 12, 17};
      wr(8'h4C, 32'h3A);
      for (int m = 0; m < 5; m++) begin
         c = 0;
         wr(8'h48, {24'h0, m[2:0], 3'b001, m[0], ~m[0]});
         settle();
         chk(r20, m[0]);
         chk(cs, !m[0]);
         @(posedge clk_i);
         sg <= 1'b1;
         count_hi(1'b1, 30, c);
         @(posedge clk_i);
         sg <= 1'b0;
         count_hi(1'b1, 30, c);
         chk(c, exp[m]);
      end
      @(posedge clk_i);
      fp <= 1'b1;
      settle();
      chk(fa, 1'b1);
      @(posedge clk_i);
      fp <= 1'b0;
   endtask
   task automatic t_cmd();
      logic [31:0] q;
      wr(CMD_ADDR, {16'h0, 8'h3C, 2'b11, IDX_RD_SLICE, 1'b0});
      rd(8'h50, q);
      chk(q, 32'h3C);
      wr(CMD_ADDR, {16'h0, 8'h77, 2'b01, IDX_RD_SLICE, 1'b0});
      rd(8'h50, q);
      chk(q, 32'h3C);
      wr(CMD_ADDR, {16'h0, 8'h00, 2'b10, IDX_RD_SLICE, 1'b0});
      rd(CMD_ADDR, q);
      chk(q, 32'h3C);
      wr(8'h4C, 32'hFF);
      rd(8'h4C, q);
      chk(q, 32'h3F);
      wr(8'h51, 32'hFF);
      rd(8'h51, q);
      chk(q, 32'h0);
   endtask

   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_mode();
      t_slice();
      t_half();
      t_pulse();
      t_short();
      t_fast();
      t_cmd();
      conclude();
   end
endmodule

// File: bench/rcc_host_model.sv
// host-side wishbone master model issuing classic single cycles
module rcc_host_model (
   input  wire logic                      clk_i,
   input  wire logic                      ack_i,
   input  wire logic [rcc_pkg::WB_DW-1:0] dat_i,
   output logic                           cyc_o,
   output logic                           stb_o,
   output logic                           we_o,
   output logic      [rcc_pkg::WB_AW-1:0] adr_o,
   output logic      [3:0]                sel_o,
   output logic      [rcc_pkg::WB_DW-1:0] dat_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import rcc_pkg::*;
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o  = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'h0;
      dat_o = 32'h0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      logic [31:0] dm;
      dm = (w && a == {1'b0, IDX_SRV_MODE, 2'b00}) ? (d & {24'h0, MASK_SRV_MODE}) : d;
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= w;
      adr_o <= a;
      sel_o <= 4'hF;
      dat_o <= dm;
      do @(posedge clk_i); while (ack_i !== 1'b1);
      q = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      dat_o <= ~dm;
   endtask
endmodule

// File: core/rcc_cfg_regs.sv
// read-channel configuration register bank with wishbone slave, short timer and fast-attack gen
// Summary of operation
// RL1 - hold charge-rate code 00 selects x2.5, 01 x1.5, 10 x1.0
// RL2 - host writes zero into unused bits of the charge-rate/slice-mode register
// RL3 - envelope select zero: DC slicing everywhere; one: envelope in read only
// RL4 - host sets half-window step 3 for fastest band up to 7 for slowest
// RL5 - internal ECL load connects only when write outputs are ECL and bit set
// RL6 - polarity bit zero gives active-high pulse output, one active-low
// RL7 - composite bit zero passes one polarity, one passes both polarities
// RL8 - short-timer code zero disables, code n gives n plus two counts
// RL9 - AGC input short is the OR of external pin and internal timer
// RL10 - AGC output-enable bit disables differential AGC outputs at zero
// RL11 - detected-pulse output driven only while its enable bit is one
// RL12 - fast attack is OR of external pin and generator; mode 000 pin only
// RL13 - mode 001 falling edge width A, 010 rising width B, 011 both
// RL14 - mode 100 makes pulses of width C
// RL15 - width code zero gives zero counts, code n gives 2n plus three
// RL16 - charge-ratio bit selects 5:1 at zero and 20:1 at one
// RL17 - charge-current bit zero selects larger current, one the 250 uA current
// RL18 - servo gate low: read low-slice field sets low slice level
// RL19 - servo gate low: read high-slice field sets high slice level
// RL20 - servo gate high: servo low and high fields set DC slice levels
// RL21 - command byte: bit7 set, bit6 write, bits5..1 register address
module rcc_cfg_regs #(
   parameter int unsigned COUNT_DIV = rcc_pkg::COUNT_DIV_DEF
) (
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   input  wire logic                        wb_cyc_i,
   input  wire logic                        wb_stb_i,
   input  wire logic                        wb_we_i,
   input  wire logic [rcc_pkg::WB_AW-1:0]   wb_adr_i,
   input  wire logic [3:0]                  wb_sel_i,
   input  wire logic [rcc_pkg::WB_DW-1:0]   wb_dat_i,
   output logic      [rcc_pkg::WB_DW-1:0]   wb_dat_o,
   output logic                             wb_ack_o,
   input  wire logic                        servo_gate_i,
   input  wire logic                        write_out_type_select_i,
   input  wire logic                        pulse_pos_i,
   input  wire logic                        pulse_neg_i,
   input  wire logic                        short_pin_i,
   input  wire logic                        fast_attack_pin_i,
   output logic      [2:0]                  hold_rate_sel_o,
   output logic                             env_slice_active_o,
   output logic      [3:0]                  low_slice_o,
   output logic      [3:0]                  high_slice_o,
   output logic      [4:0]                  half_window_step_o,
   output logic                             ecl_load_on_o,
   output logic                             detected_pulse_output_o,
   output logic                             detected_pulse_output_oe_n_o,
   output logic                             agc_diff_outputs_en_o,
   output logic                             agc_input_short_o,
   output logic                             fast_attack_o,
   output logic                             agc_ratio_20_o,
   output logic                             agc_charge_small_o
);
   import rcc_pkg::*;

   rcc_state_t st_reg;
   rcc_state_t st_next;

   logic       wb_req;
   logic       wr_en;
   logic [4:0] wr_idx;
   logic [7:0] wr_data;
   logic       rd_cmd;
   logic [4:0] rd_cmd_idx;
   logic       tick;
   logic       sg_rise;
   logic       sg_fall;
   logic [4:0] fa_load;
   logic       fa_trig;

   function automatic logic is_mapped(input logic [4:0] idx);
      case (idx)
         IDX_SRV_MODE, IDX_HALF_WIN, IDX_AGC_SHORT, IDX_FAST_ATT,
         IDX_FA_WIDTH, IDX_RD_SLICE, IDX_SV_SLICE: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   function automatic logic [7:0] reg_read(input rcc_cfg_t c, input logic [4:0] idx);
      case (idx)
         IDX_SRV_MODE:  reg_read = c.srv_mode;
         IDX_HALF_WIN:  reg_read = c.half_win;
         IDX_AGC_SHORT: reg_read = c.agc_short;
         IDX_FAST_ATT:  reg_read = c.fast_att;
         IDX_FA_WIDTH:  reg_read = c.fa_width;
         IDX_RD_SLICE:  reg_read = c.rd_slice;
         IDX_SV_SLICE:  reg_read = c.sv_slice;
         default:       reg_read = 8'h00;
      endcase
   endfunction

   // reserved bits are masked so they always read back as zero, whatever the host sends
   function automatic rcc_cfg_t reg_write(input rcc_cfg_t c, input logic [4:0] idx,
                                          input logic [7:0] d);
      rcc_cfg_t r;
      r = c;
      case (idx)
         IDX_SRV_MODE:  r.srv_mode  = rcc_srv_mode_t'(d & MASK_SRV_MODE); // [RL2]
         IDX_HALF_WIN:  r.half_win  = rcc_half_win_t'(d & MASK_FULL);
         IDX_AGC_SHORT: r.agc_short = rcc_agc_short_t'(d & MASK_FULL);
         IDX_FAST_ATT:  r.fast_att  = rcc_fast_att_t'(d & MASK_FULL);
         IDX_FA_WIDTH:  r.fa_width  = rcc_fa_width_t'(d & MASK_FA_WIDTH);
         IDX_RD_SLICE:  r.rd_slice  = rcc_slice_t'(d & MASK_FULL);
         IDX_SV_SLICE:  r.sv_slice  = rcc_slice_t'(d & MASK_FULL);
         default:       r = c;
      endcase
      return r;
   endfunction

   function automatic logic [4:0] width_count(input logic [2:0] code);
      logic [4:0] n;
      n = 5'h00;
      if (code != 3'h0) begin
         n = {1'b0, code, 1'b0} + WIDTH_OFFSET; // [RL15]
      end
      return n;
   endfunction

   function automatic logic [6:0] short_count(input logic [5:0] code);
      logic [6:0] n;
      n = 7'h00;
      if (code != 6'h00) begin
         n = {1'b0, code} + SHORT_OFFSET; // [RL8]
      end
      return n;
   endfunction

   always_comb begin
      st_next = st_reg;
      wb_req  = wb_cyc_i && wb_stb_i && !st_reg.ack;
      wr_en   = 1'b0;
      wr_idx  = wb_adr_i[6:2];
      wr_data = wb_dat_i[7:0];
      rd_cmd  = 1'b0;
      rd_cmd_idx = wb_dat_i[CMD_ADR_MSB:CMD_ADR_LSB];

      // bus slave: every request is acked one cycle later, unmapped reads give zero
      st_next.ack   = wb_req;
      st_next.rdata = 8'h00;
      if (wb_req && (wb_adr_i == CMD_ADDR)) begin
         if (wb_we_i && (wb_sel_i[1:0] == 2'b11)) begin
            st_next.cmd_bad = !wb_dat_i[CMD_VALID_BIT]; // [RL21]
            if (wb_dat_i[CMD_VALID_BIT]) begin
               if (wb_dat_i[CMD_WRITE_BIT]) begin
                  wr_en   = 1'b1;
                  wr_idx  = wb_dat_i[CMD_ADR_MSB:CMD_ADR_LSB];
                  wr_data = wb_dat_i[15:8];
               end else begin
                  rd_cmd = 1'b1;
               end
            end
         end
         st_next.rdata = st_reg.cmd_rdata;
      end else if (wb_req && (wb_adr_i[1:0] == 2'b00) && !wb_adr_i[7]) begin
         if (wb_we_i) begin
            wr_en = wb_sel_i[0];
         end else begin
            st_next.rdata = reg_read(st_reg.cfg, wb_adr_i[6:2]);
         end
      end
      if (rd_cmd) begin
         st_next.cmd_rdata = reg_read(st_reg.cfg, rd_cmd_idx); // [RL21]
      end
      if (wr_en && is_mapped(wr_idx)) begin
         st_next.cfg = reg_write(st_reg.cfg, wr_idx, wr_data);
      end

      // count tick from the divider; default rate is every clock
      tick = (st_reg.tick_cnt == 8'(COUNT_DIV - 1));
      st_next.tick_cnt = tick ? 8'h00 : st_reg.tick_cnt + 8'h01;

      // short timer restarts on every write of its register; zero code leaves it idle
      if (wr_en && (wr_idx == IDX_AGC_SHORT)) begin
         st_next.short_cnt = short_count(wr_data[5:0]); // [RL8]
      end else if (tick && (st_reg.short_cnt != 7'h00)) begin
         st_next.short_cnt = st_reg.short_cnt - 7'h01;
      end

      // fast-attack generator, triggered by servo-gate edges
      st_next.sg_q = servo_gate_i;
      sg_rise = servo_gate_i && !st_reg.sg_q;
      sg_fall = !servo_gate_i && st_reg.sg_q;
      fa_trig = 1'b0;
      fa_load = 5'h00;
      case (rcc_fa_mode_t'(st_reg.cfg.fast_att.fast_attack_gen_mode))
         FA_EXT_ONLY: begin
            fa_trig = 1'b0; // [RL12]
         end
         FA_FALL: begin
            fa_trig = sg_fall; // [RL13]
            fa_load = width_count(st_reg.cfg.fast_att.fast_attack_width_a);
         end
         FA_RISE: begin
            fa_trig = sg_rise; // [RL13]
            fa_load = width_count(st_reg.cfg.fa_width.fast_attack_width_b);
         end
         FA_BOTH: begin
            fa_trig = sg_rise || sg_fall; // [RL13]
            fa_load = sg_rise ? width_count(st_reg.cfg.fa_width.fast_attack_width_b)
                              : width_count(st_reg.cfg.fast_att.fast_attack_width_a);
         end
         FA_WIDTH_C: begin
            // trigger is not defined elsewhere; the rising servo-gate edge is used
            fa_trig = sg_rise; // [RL14]
            fa_load = width_count(st_reg.cfg.fa_width.fast_attack_width_c);
         end
         default: begin
            fa_trig = 1'b0;
         end
      endcase
      if (fa_trig) begin
         st_next.fa_cnt = fa_load;
      end else if (tick && (st_reg.fa_cnt != 5'h00)) begin
         st_next.fa_cnt = st_reg.fa_cnt - 5'h01;
      end

      // registered outputs; each follows its cause one clock later
      case (st_reg.cfg.srv_mode.hold_rate)
         HOLD_X25: st_next.out.hold_rate_sel = 3'b100; // [RL1]
         HOLD_X15: st_next.out.hold_rate_sel = 3'b010; // [RL1]
         HOLD_X10: st_next.out.hold_rate_sel = 3'b001; // [RL1]
         default:  st_next.out.hold_rate_sel = 3'b000;
      endcase
      st_next.out.env_slice_active = st_reg.cfg.srv_mode.env_slice_sel && !servo_gate_i; // [RL3]
      if (servo_gate_i) begin
         st_next.out.low_slice  = st_reg.cfg.sv_slice.low;  // [RL20]
         st_next.out.high_slice = st_reg.cfg.sv_slice.high; // [RL20]
      end else begin
         st_next.out.low_slice  = st_reg.cfg.rd_slice.low;  // [RL18]
         st_next.out.high_slice = st_reg.cfg.rd_slice.high; // [RL19]
      end
      st_next.out.half_window_step = st_reg.cfg.half_win.half_window_step;
      st_next.out.ecl_load_on = st_reg.cfg.half_win.ecl_internal_load
                                && write_out_type_select_i; // [RL5]
      st_next.out.pulse_out = ((st_reg.cfg.half_win.pulse_out_composite && pulse_neg_i)
                               || pulse_pos_i) // [RL7]
                              ^ st_reg.cfg.half_win.pulse_out_polarity; // [RL6]
      st_next.out.pulse_out_oe_n = !st_reg.cfg.agc_short.pulse_out_enable; // [RL11]
      st_next.out.agc_out_en     = st_reg.cfg.agc_short.agc_out_enable;   // [RL10]
      st_next.out.agc_short      = short_pin_i || (st_next.short_cnt != 7'h00); // [RL9]
      st_next.out.fast_attack    = fast_attack_pin_i || (st_next.fa_cnt != 5'h00); // [RL12]
      st_next.out.ratio_20       = st_reg.cfg.fast_att.agc_charge_ratio;   // [RL16]
      st_next.out.charge_small   = st_reg.cfg.fast_att.agc_charge_current; // [RL17]
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= '0;
         st_reg.cfg <= CFG_RST;
         st_reg.out.pulse_out_oe_n <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign wb_dat_o = {24'h000000, st_reg.rdata};
   assign wb_ack_o = st_reg.ack;
   assign hold_rate_sel_o = st_reg.out.hold_rate_sel;
   assign env_slice_active_o = st_reg.out.env_slice_active;
   assign low_slice_o = st_reg.out.low_slice;
   assign high_slice_o = st_reg.out.high_slice;
   assign half_window_step_o = st_reg.out.half_window_step;
   assign ecl_load_on_o = st_reg.out.ecl_load_on;
   assign detected_pulse_output_o = st_reg.out.pulse_out;
   assign detected_pulse_output_oe_n_o = st_reg.out.pulse_out_oe_n;
   assign agc_diff_outputs_en_o = st_reg.out.agc_out_en;
   assign agc_input_short_o = st_reg.out.agc_short;
   assign fast_attack_o = st_reg.out.fast_attack;
   assign agc_ratio_20_o = st_reg.out.ratio_20;
   assign agc_charge_small_o = st_reg.out.charge_small;

   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   bus_ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   // the reset edge itself is skipped: the select is still clear there
   hold_rate_dec_a: assert property ( // [RL1]
      !$past(rst_i) |->
         (hold_rate_sel_o[2] == ($past(st_reg.cfg.srv_mode.hold_rate) == HOLD_X25))
          && (hold_rate_sel_o[0] == ($past(st_reg.cfg.srv_mode.hold_rate) == HOLD_X10)))
      else $error("charge-rate select does not match code");

   env_slice_mode_a: assert property ( // [RL3]
      env_slice_active_o |-> $past(st_reg.cfg.srv_mode.env_slice_sel) && !$past(servo_gate_i))
      else $error("envelope slicing active outside read mode");

   slice_source_a: assert property ( // [RL20]
      servo_gate_i |=> low_slice_o == $past(st_reg.cfg.sv_slice.low)
                       && high_slice_o == $past(st_reg.cfg.sv_slice.high))
      else $error("servo slice levels not selected");

   read_slice_a: assert property ( // [RL18]
      !servo_gate_i |=> low_slice_o == $past(st_reg.cfg.rd_slice.low))
      else $error("read low slice not selected");

   ecl_load_gate_a: assert property ( // [RL5]
      ecl_load_on_o |-> $past(write_out_type_select_i))
      else $error("ecl load on without ecl mode");

   pulse_polarity_a: assert property ( // [RL6]
      (!pulse_pos_i && !pulse_neg_i) |=>
         detected_pulse_output_o == $past(st_reg.cfg.half_win.pulse_out_polarity))
      else $error("idle pulse level wrong for polarity");

   pulse_enable_a: assert property ( // [RL11]
      !detected_pulse_output_oe_n_o |-> $past(st_reg.cfg.agc_short.pulse_out_enable))
      else $error("pulse output driven while disabled");

   short_or_pin_a: assert property ( // [RL9]
      short_pin_i |=> agc_input_short_o)
      else $error("external short not passed");

   short_load_a: assert property ( // [RL8]
      (wr_en && wr_idx == IDX_AGC_SHORT && wr_data[5:0] != 6'h00) |=>
         st_reg.short_cnt == {1'b0, $past(wr_data[5:0])} + SHORT_OFFSET ##1 agc_input_short_o)
      else $error("short timer load wrong");

   fa_fall_width_a: assert property ( // [RL13]
      (sg_fall && st_reg.cfg.fast_att.fast_attack_gen_mode == 3'b001) |=>
         st_reg.fa_cnt == width_count($past(st_reg.cfg.fast_att.fast_attack_width_a)))
      else $error("fast-attack width A not loaded on falling edge");

   fa_pin_or_a: assert property ( // [RL12]
      fast_attack_pin_i |=> fast_attack_o)
      else $error("external fast attack not passed");

   cmd_write_a: assert property ( // [RL21]
      (wb_req && wb_we_i && wb_adr_i == CMD_ADDR && wb_sel_i[1:0] == 2'b11
       && wb_dat_i[7:6] == 2'b11 && wb_dat_i[5:1] == IDX_RD_SLICE) |=>
         st_reg.cfg.rd_slice == $past(wb_dat_i[15:8]))
      else $error("command write did not reach register");

   agc_out_en_a: assert property ( // [RL10]
      agc_diff_outputs_en_o == $past(st_reg.cfg.agc_short.agc_out_enable))
      else $error("agc output enable does not follow its bit");

   charge_ratio_a: assert property ( // [RL16]
      agc_ratio_20_o == $past(st_reg.cfg.fast_att.agc_charge_ratio))
      else $error("charge ratio does not follow its bit");

   charge_current_a: assert property ( // [RL17]
      agc_charge_small_o == $past(st_reg.cfg.fast_att.agc_charge_current))
      else $error("charge current does not follow its bit");

   composite_pass_a: assert property ( // [RL7]
      (!pulse_pos_i && pulse_neg_i) |=> detected_pulse_output_o
         == ($past(st_reg.cfg.half_win.pulse_out_composite)
             ^ $past(st_reg.cfg.half_win.pulse_out_polarity)))
      else $error("negative pulse passing wrong for composite setting");

   read_high_slice_a: assert property ( // [RL19]
      !servo_gate_i |=> high_slice_o == $past(st_reg.cfg.rd_slice.high))
      else $error("read high slice not selected");

   fa_width_c_a: assert property ( // [RL14]
      (sg_rise && st_reg.cfg.fast_att.fast_attack_gen_mode == 3'b100) |=>
         st_reg.fa_cnt == width_count($past(st_reg.cfg.fa_width.fast_attack_width_c)))
      else $error("fast-attack width C not loaded");

   fa_ext_only_a: assert property ( // [RL12]
      (st_reg.cfg.fast_att.fast_attack_gen_mode == 3'b000 && st_reg.fa_cnt == 5'h00
       && !fast_attack_pin_i) |=> !fast_attack_o)
      else $error("fast attack active with generator off");

   wb_write_cov: cover property (wb_req && wb_we_i ##1 wb_ack_o);
   fa_pulse_cov: cover property (sg_rise && fa_trig ##1 fast_attack_o);
   short_pulse_cov: cover property (!short_pin_i && agc_input_short_o);
   cmd_read_cov: cover property (rd_cmd ##1 wb_ack_o);
   fa_fall_cov: cover property (sg_fall && fa_trig ##1 fast_attack_o);

endmodule

// File: core/rcc_pkg.sv
// package: register map, field layouts, codes and state types of the read-channel config bank
package rcc_pkg;

   // wishbone geometry
   localparam int unsigned WB_AW = 8;
   localparam int unsigned WB_DW = 32;

   // register indices; byte address is four times the index
   localparam logic [4:0] IDX_SRV_MODE  = 5'h0D;
   localparam logic [4:0] IDX_HALF_WIN  = 5'h0F;
   localparam logic [4:0] IDX_AGC_SHORT = 5'h11;
   localparam logic [4:0] IDX_FAST_ATT  = 5'h12;
   localparam logic [4:0] IDX_FA_WIDTH  = 5'h13;
   localparam logic [4:0] IDX_RD_SLICE  = 5'h14;
   localparam logic [4:0] IDX_SV_SLICE  = 5'h15;

   // command-byte port, byte address of its own
   localparam logic [7:0] CMD_ADDR      = 8'h80;
   localparam int unsigned CMD_VALID_BIT = 7;
   localparam int unsigned CMD_WRITE_BIT = 6;
   localparam int unsigned CMD_ADR_MSB   = 5;
   localparam int unsigned CMD_ADR_LSB   = 1;

   // writable-bit masks, reserved bits are stored as zero
   localparam logic [7:0] MASK_SRV_MODE = 8'h83;
   localparam logic [7:0] MASK_FA_WIDTH = 8'h3F;
   localparam logic [7:0] MASK_FULL     = 8'hFF;

   // servo hold charge-rate codes
   localparam logic [1:0] HOLD_X25 = 2'h0;
   localparam logic [1:0] HOLD_X15 = 2'h1;
   localparam logic [1:0] HOLD_X10 = 2'h2;

   // count encodings for nonzero codes: short n = code + 2, width n = 2 * code + 3
   localparam logic [6:0] SHORT_OFFSET = 7'h02;
   localparam logic [4:0] WIDTH_OFFSET = 5'h03;

   // default divider for the count tick
   localparam int unsigned COUNT_DIV_DEF = 1;

   typedef enum logic [2:0] {
      FA_EXT_ONLY = 3'b000,
      FA_FALL     = 3'b001,
      FA_RISE     = 3'b010,
      FA_BOTH     = 3'b011,
      FA_WIDTH_C  = 3'b100
   } rcc_fa_mode_t;

   typedef struct packed {
      logic       env_slice_sel;
      logic [4:0] rsv;
      logic [1:0] hold_rate;
   } rcc_srv_mode_t;

   typedef struct packed {
      logic [4:0] half_window_step;
      logic       ecl_internal_load;
      logic       pulse_out_composite;
      logic       pulse_out_polarity;
   } rcc_half_win_t;

   typedef struct packed {
      logic       pulse_out_enable;
      logic       agc_out_enable;
      logic [5:0] agc_input_short_count;
   } rcc_agc_short_t;

   typedef struct packed {
      logic [2:0] fast_attack_gen_mode;
      logic [2:0] fast_attack_width_a;
      logic       agc_charge_ratio;
      logic       agc_charge_current;
   } rcc_fast_att_t;

   typedef struct packed {
      logic [1:0] rsv;
      logic [2:0] fast_attack_width_c;
      logic [2:0] fast_attack_width_b;
   } rcc_fa_width_t;

   typedef struct packed {
      logic [3:0] high;
      logic [3:0] low;
   } rcc_slice_t;

   typedef struct packed {
      rcc_srv_mode_t  srv_mode;
      rcc_half_win_t  half_win;
      rcc_agc_short_t agc_short;
      rcc_fast_att_t  fast_att;
      rcc_fa_width_t  fa_width;
      rcc_slice_t     rd_slice;
      rcc_slice_t     sv_slice;
   } rcc_cfg_t;

   localparam rcc_cfg_t CFG_RST = '0;

   typedef struct packed {
      logic [2:0] hold_rate_sel;
      logic       env_slice_active;
      logic [3:0] low_slice;
      logic [3:0] high_slice;
      logic [4:0] half_window_step;
      logic       ecl_load_on;
      logic       pulse_out;
      logic       pulse_out_oe_n;
      logic       agc_out_en;
      logic       agc_short;
      logic       fast_attack;
      logic       ratio_20;
      logic       charge_small;
   } rcc_out_t;

   typedef struct packed {
      rcc_cfg_t   cfg;
      logic       ack;
      logic [7:0] rdata;
      logic [7:0] cmd_rdata;
      logic       cmd_bad;
      logic       sg_q;
      logic [7:0] tick_cnt;
      logic [6:0] short_cnt;
      logic [4:0] fa_cnt;
      rcc_out_t   out;
   } rcc_state_t;

endpackage
